/* File: hdl/ump_arbiter.sv */
`timescale 1ns/1ns
`include "ump_defines.svh"

// fixed priority arbiter, index 0 highest; an owner keeps the bus while
// it keeps requesting, which is what makes a lock hold
module ump_arbiter (
  input wire logic clock,
  input wire logic rst_n,
  arb_if.arbiter   bus
);

  ump_pkg::arb_st_t a;
  ump_pkg::arb_st_t next_a;

  ////////////////////////////////////////////////////////////////////////////
  // re-arbitrate only when the current owner lets go
  always_comb begin
    next_a = a;
    if ((a.grant & bus.req) == `UMP_GRANT_RST) begin
      next_a.grant = `UMP_GRANT_RST;
      for (int i = `UMP_MASTERS - 1; i >= 0; i--) begin
        if (bus.req[i]) begin
          next_a.grant = `UMP_GRANT_RST;
          next_a.grant[i] = 1'b1; // R1
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      a <= '0;
    end else begin
      a <= next_a;
    end
  end

  assign bus.grant = a.grant;

  ////////////////////////////////////////////////////////////////////////////
  chk_grant_onehot: assert property (@(posedge clock) disable iff (!rst_n) // R1
    $onehot0(a.grant))
    else $error("more than one master granted");
  chk_highest_prio: assert property ( // R1
    @(posedge clock) disable iff (!rst_n)
    ((a.grant & bus.req) == `UMP_GRANT_RST) && (bus.req != `UMP_GRANT_RST)
      |=> a.grant == $past(bus.req & (~bus.req + 4'h1)))
    else $error("grant did not go to highest priority requester");

endmodule

/* File: hdl/ump_sync.sv */
`timescale 1ns/1ns

// two flop level synchroniser; only the second stage leaves the module
module ump_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [1:0][W-1:0] stages;
  logic [1:0][W-1:0] next_stages;

  // stage 0 feeds stage 1 and nothing else
  always_comb begin
    next_stages = {stages[0], d};
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stages <= '0;
    end else begin
      stages <= next_stages;
    end
  end

  assign q = stages[1];

endmodule

/* File: hdl/user_master_bus_port.sv */
`timescale 1ns/1ns
`include "ump_defines.svh"

// Contract
// R1: arbiter grants highest priority requester
// R2: user holds ownership request across sequence
// R3: after lock, granted flag and acknowledge rise
// R4: user paces on acknowledge, not granted
// R5: drop request, strobe once, lock released
// R6: single transfer works without ownership request
// R7: write strobe carries valid address, data
// R8: acknowledge stays high until next strobe
// R9: back-to-back writes need no fresh lock
// R10: acknowledge drops on strobe, returns when done
// R11: read strobe one cycle; acknowledge means data
// R12: consecutive reads keep read request high
// R13: burst indicator raised with lock, direction
// R14: bursts always four beats, four-entry fifo
// R15: burst write strobes four consecutive cycles
// R16: port increments burst address by size step
// R17: burst read acknowledge high four cycles
// R18: acknowledge drops only after next strobe
// R19: address and data lanes pass unchanged
// R20: size codes 10, 01, 00; 11 invalid
// R21: narrow writes replicated on all lanes
// R22: retry pulse on fifo conflict or bus
// R23: error with acknowledge until next strobe
// R24: user outputs registered; requests cross safely
// R25: user reset idles everything, responses low; the bus side keeps its state until rst_n
module user_master_bus_port (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    master_port_clock,
  input  wire logic                    master_port_reset,
  input  wire logic                    bus_ownership_request,
  input  wire logic                    write_request,
  input  wire logic                    read_request,
  input  wire logic                    burst_indicator,
  input  wire logic [1:0]              transfer_size,
  input  wire logic [`UMP_ADDR_W-1:0]  master_address,
  input  wire logic [`UMP_DATA_W-1:0]  master_write_data,
  input  wire logic                    request_strobe,
  output logic                         master_acknowledge,
  output logic                         retry_response,
  output logic                         error_response,
  output logic      [`UMP_DATA_W-1:0]  master_read_data,
  output logic                         ownership_granted_dbg,
  input  wire logic [2:0]              other_master_request,
  output logic      [2:0]              other_master_grant,
  output logic                         sysbus_start,
  output logic                         sysbus_write,
  output logic      [1:0]              sysbus_size,
  output logic      [`UMP_ADDR_W-1:0]  sysbus_addr,
  output logic      [`UMP_DATA_W-1:0]  sysbus_wdata,
  input  wire logic [`UMP_DATA_W-1:0]  sysbus_rdata,
  input  wire logic                    sysbus_done,
  input  wire logic                    sysbus_retry,
  input  wire logic                    sysbus_error
);

  ump_pkg::user_st_t u;
  ump_pkg::user_st_t next_u;
  ump_pkg::bus_st_t  b;
  ump_pkg::bus_st_t  next_b;

  logic       issue;
  logic       bus_finish;
  logic       req_sync;
  logic       req_evt;
  logic [1:0] back_q;
  logic       done_evt;
  logic       port_req;
  logic       port_grant;

  arb_if arb ();

  ////////////////////////////////////////////////////////////////////////////
  // crossings: command toggle into the bus clock, done and granted back
  ump_sync #(.W(1)) req_cross (
    .clock (clock),
    .rst_n (rst_n),
    .d     (u.req_tog),
    .q     (req_sync)
  );

  ump_sync #(.W(2)) back_cross (
    .clock (master_port_clock),
    .rst_n (!master_port_reset),
    .d     ({b.done_tog, b.granted}),
    .q     (back_q)
  );

  // holding registers stay still until the toggle returns, so the wide
  // command and result words need no synchroniser of their own
  assign req_evt  = req_sync != b.req_seen; // R24
  assign done_evt = back_q[1] != u.done_seen;

  ////////////////////////////////////////////////////////////////////////////
  // arbitration among this port and the other bus masters
  assign port_req = b.lock_held || (b.state != ump_pkg::B_IDLE);
  assign arb.req  = {port_req, other_master_request};
  assign port_grant = arb.grant[3];

  ump_arbiter arbiter (
    .clock (clock),
    .rst_n (rst_n),
    .bus   (arb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // user side sequencer, runs on the link clock
  always_comb begin
    next_u = u;
    issue = 1'b0;
    next_u.retry = 1'b0;
    next_u.done_seen = back_q[1];
    unique case (u.state)
      ump_pkg::U_IDLE: begin
        next_u.ack = 1'b1;
        next_u.state = ump_pkg::U_READY;
      end
      ump_pkg::U_READY: begin
        if (request_strobe) begin
          next_u.err = 1'b0; // R23
          if (u.lock_held && !bus_ownership_request) begin
            next_u.kind = ump_pkg::K_UNLOCK; // R5
            issue = 1'b1;
          end else if (write_request || read_request) begin
            // lanes are carried as given, no swapping
            next_u.addr = master_address; // R19
            next_u.size = transfer_size;
            next_u.write = write_request;
            next_u.burst = burst_indicator;
            next_u.fifo[`UMP_FIRST_BEAT] = master_write_data; // R7
            if (transfer_size == `UMP_SIZE_BAD) begin
              next_u.err = 1'b1; // R20
            end else if (write_request && burst_indicator) begin
              next_u.wcnt = `UMP_NEXT_BEAT; // R15
              next_u.ack = 1'b0;
              next_u.state = ump_pkg::U_COLLECT;
            end else begin
              // no lock needed: the bus side arbitrates on its own
              next_u.kind = ump_pkg::K_XFER; // R6
              issue = 1'b1;
            end
          end
        end else if (bus_ownership_request && !u.lock_held &&
                     (write_request || read_request)) begin
          next_u.kind = ump_pkg::K_LOCK; // R9
          issue = 1'b1;
        end
      end
      ump_pkg::U_COLLECT: begin
        if (request_strobe) begin
          if (read_request) begin
            // read while write fifo holds data: refuse, drop the beats
            next_u.retry = 1'b1; // R22
            next_u.ack = 1'b1;
            next_u.state = ump_pkg::U_READY;
          end else begin
            next_u.fifo[u.wcnt] = master_write_data; // R14
            next_u.wcnt = u.wcnt + 2'h1;
            if (u.wcnt == `UMP_LAST_BEAT) begin
              next_u.kind = ump_pkg::K_XFER;
              issue = 1'b1;
            end
          end
        end
      end
      ump_pkg::U_BUSY: begin
        if (request_strobe && write_request) begin
          next_u.retry = 1'b1; // R22
        end
        if (done_evt) begin
          next_u.ack = 1'b1; // R8
          next_u.state = ump_pkg::U_READY;
          unique case (u.kind)
            ump_pkg::K_LOCK: begin
              next_u.lock_held = 1'b1; // R3
            end
            ump_pkg::K_UNLOCK: begin
              next_u.lock_held = 1'b0;
            end
            default: begin
              if (b.res_retry) begin
                next_u.retry = 1'b1; // R22
              end else if (b.res_err) begin
                next_u.err = 1'b1; // R23
              end else if (!u.write) begin
                next_u.rdata = b.res[`UMP_FIRST_BEAT]; // R11
                if (u.burst) begin
                  next_u.rcnt = `UMP_NEXT_BEAT;
                  next_u.state = ump_pkg::U_RDOUT;
                end
              end
            end
          endcase
        end
      end
      ump_pkg::U_RDOUT: begin
        // one word per cycle; acknowledge stays up afterwards
        next_u.rdata = b.res[u.rcnt]; // R17
        next_u.rcnt = u.rcnt + 2'h1;
        if (u.rcnt == `UMP_LAST_BEAT) begin
          next_u.state = ump_pkg::U_READY; // R18
        end
      end
      default: begin
        next_u.state = ump_pkg::U_IDLE;
      end
    endcase
    if (issue) begin
      next_u.req_tog = ~u.req_tog; // R24
      next_u.ack = 1'b0; // R10
      next_u.state = ump_pkg::U_BUSY;
    end
  end

  // active-high user reset clears every response
  always_ff @(posedge master_port_clock) begin
    if (master_port_reset) begin
      u <= '0; // R25
    end else begin
      u <= next_u;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system bus side sequencer
  always_comb begin
    next_b = b;
    bus_finish = 1'b0;
    next_b.start = 1'b0;
    next_b.req_seen = req_sync;
    next_b.granted = b.lock_held && port_grant; // R3
    unique case (b.state)
      ump_pkg::B_IDLE: begin
        if (req_evt) begin
          next_b.res_retry = 1'b0;
          next_b.res_err = 1'b0;
          next_b.beat = `UMP_FIRST_BEAT;
          if (u.kind == ump_pkg::K_UNLOCK) begin
            next_b.lock_held = 1'b0; // R5
            bus_finish = 1'b1;
          end else begin
            next_b.state = ump_pkg::B_ARB;
          end
        end
      end
      ump_pkg::B_ARB: begin
        if (port_grant) begin
          if (u.kind == ump_pkg::K_LOCK) begin
            next_b.lock_held = 1'b1; // R3
            bus_finish = 1'b1;
          end else begin
            next_b.state = ump_pkg::B_START;
          end
        end
      end
      ump_pkg::B_START: begin
        // byte, half and word steps are 1, 2 and 4
        next_b.addr = u.addr + (18'(b.beat) << u.size); // R16
        next_b.wdata = u.fifo[b.beat]; // R19
        next_b.write = u.write;
        next_b.size = u.size;
        next_b.start = 1'b1;
        next_b.state = ump_pkg::B_WAIT;
      end
      ump_pkg::B_WAIT: begin
        if (sysbus_done) begin
          next_b.res[b.beat] = sysbus_rdata;
          if (sysbus_retry) begin
            next_b.res_retry = 1'b1; // R22
            bus_finish = 1'b1;
          end else if (sysbus_error) begin
            next_b.res_err = 1'b1; // R23
            bus_finish = 1'b1;
          end else if (!u.burst || b.beat == `UMP_LAST_BEAT) begin
            bus_finish = 1'b1; // R14
          end else begin
            next_b.beat = b.beat + 2'h1;
            next_b.state = ump_pkg::B_START;
          end
        end
      end
    endcase
    if (bus_finish) begin
      next_b.done_tog = ~b.done_tog;
      next_b.state = ump_pkg::B_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      b <= '0;
    end else begin
      b <= next_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign master_acknowledge    = u.ack;
  assign retry_response        = u.retry;
  assign error_response        = u.err;
  assign master_read_data      = u.rdata;
  assign ownership_granted_dbg = back_q[0];
  assign other_master_grant    = arb.grant[2:0];
  assign sysbus_start          = b.start;
  assign sysbus_write          = b.write;
  assign sysbus_size           = b.size;
  assign sysbus_addr           = b.addr;
  assign sysbus_wdata          = b.wdata;

  ////////////////////////////////////////////////////////////////////////////
  // checks on the user side
  chk_ack_drops_strobe: assert property ( // R10
    @(posedge master_port_clock) disable iff (master_port_reset)
    (u.state == ump_pkg::U_READY) && request_strobe && write_request &&
      !burst_indicator && (transfer_size != `UMP_SIZE_BAD)
      |=> !master_acknowledge)
    else $error("acknowledge did not drop after write strobe");
  chk_ack_holds: assert property ( // R8
    @(posedge master_port_clock) disable iff (master_port_reset)
    master_acknowledge && !request_strobe &&
      !(bus_ownership_request && !u.lock_held)
      |=> master_acknowledge)
    else $error("acknowledge fell without a strobe");
  chk_retry_one_cycle: assert property ( // R22
    @(posedge master_port_clock) disable iff (master_port_reset)
    retry_response |=> !retry_response)
    else $error("retry held longer than one cycle");
  chk_err_with_ack: assert property ( // R23
    @(posedge master_port_clock) disable iff (master_port_reset)
    error_response |-> master_acknowledge)
    else $error("error shown without acknowledge");
  chk_err_holds: assert property ( // R23
    @(posedge master_port_clock) disable iff (master_port_reset)
    error_response && !request_strobe |=> error_response)
    else $error("error dropped without a strobe");
  chk_burst_read_ack: assert property ( // R17
    @(posedge master_port_clock) disable iff (master_port_reset)
    (u.state == ump_pkg::U_BUSY) && (next_u.state == ump_pkg::U_RDOUT)
      |=> master_acknowledge [*4])
    else $error("burst read acknowledge not held four cycles");
  chk_lock_ack: assert property ( // R3
    @(posedge master_port_clock) disable iff (master_port_reset)
    (u.state == ump_pkg::U_BUSY) && done_evt && (u.kind == ump_pkg::K_LOCK)
      |=> master_acknowledge && u.lock_held)
    else $error("lock won but acknowledge not raised");

  // checks on the bus side
  chk_unlock_release: assert property ( // R5
    @(posedge clock) disable iff (!rst_n)
    (b.state == ump_pkg::B_IDLE) && req_evt && (u.kind == ump_pkg::K_UNLOCK)
      |=> !b.lock_held ##[1:3] !port_grant || b.state != ump_pkg::B_IDLE)
    else $error("lock not released on unlock");
  chk_burst_step: assert property ( // R16
    @(posedge clock) disable iff (!rst_n)
    sysbus_start && (b.beat == `UMP_NEXT_BEAT)
      |-> (sysbus_addr - u.addr) == (18'h1 << u.size))
    else $error("second burst address has wrong step");

  cov_burst_read: cover property (@(posedge master_port_clock)
    disable iff (master_port_reset) u.state == ump_pkg::U_RDOUT);
  cov_retry: cover property (@(posedge master_port_clock)
    disable iff (master_port_reset) retry_response);
  cov_lock_release: cover property (@(posedge master_port_clock)
    disable iff (master_port_reset) $fell(u.lock_held));
  cov_burst_write: cover property (@(posedge clock) disable iff (!rst_n)
    sysbus_start && sysbus_write && (b.beat == `UMP_LAST_BEAT));

endmodule

/* File: include/arb_if.sv */
`timescale 1ns/1ns
`include "ump_defines.svh"

// request and grant lines between system bus masters and the arbiter
interface arb_if;
  logic [`UMP_MASTERS-1:0] req;
  logic [`UMP_MASTERS-1:0] grant;

  modport arbiter (
    input  req,
    output grant
  );

  modport client (
    output req,
    input  grant
  );
endinterface

/* File: include/ump_defines.svh */
`ifndef UMP_DEFINES_SVH
`define UMP_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////
// widths of the user side and of the system bus, and the number of bus masters
`define UMP_ADDR_W      18
`define UMP_DATA_W      36
`define UMP_MASTERS     4

////////////////////////////////////////////////////////////////////////////
// transfer size codes
`define UMP_SIZE_BYTE   2'h0
`define UMP_SIZE_HALF   2'h1
`define UMP_SIZE_WORD   2'h2
`define UMP_SIZE_BAD    2'h3

////////////////////////////////////////////////////////////////////////////
// burst shape: four beats, index of the last one
`define UMP_FIRST_BEAT  2'h0
`define UMP_NEXT_BEAT   2'h1
`define UMP_LAST_BEAT   2'h3

////////////////////////////////////////////////////////////////////////////
// reset values
`define UMP_DATA_RST    36'h0
`define UMP_GRANT_RST   4'h0

`endif

/* File: include/ump_pkg.sv */
`include "ump_defines.svh"

package ump_pkg;

  // user side sequencing
  typedef enum logic [2:0] {
    U_IDLE,
    U_READY,
    U_COLLECT,
    U_BUSY,
    U_RDOUT
  } user_state_t;

  // system bus side sequencing
  typedef enum logic [1:0] {
    B_IDLE,
    B_ARB,
    B_START,
    B_WAIT
  } bus_state_t;

  // command passed across the clock crossing
  typedef enum logic [1:0] {
    K_LOCK,
    K_UNLOCK,
    K_XFER
  } cmd_kind_t;

  typedef struct packed {
    user_state_t                       state;
    logic                              ack;
    logic                              retry;
    logic                              err;
    logic [`UMP_DATA_W-1:0]            rdata;
    logic                              lock_held;
    cmd_kind_t                         kind;
    logic                              write;
    logic                              burst;
    logic [1:0]                        size;
    logic [`UMP_ADDR_W-1:0]            addr;
    logic [3:0][`UMP_DATA_W-1:0]       fifo;
    logic [1:0]                        wcnt;
    logic [1:0]                        rcnt;
    logic                              req_tog;
    logic                              done_seen;
  } user_st_t;

  typedef struct packed {
    bus_state_t                        state;
    logic                              lock_held;
    logic                              granted;
    logic [1:0]                        beat;
    logic                              start;
    logic                              write;
    logic [1:0]                        size;
    logic [`UMP_ADDR_W-1:0]            addr;
    logic [`UMP_DATA_W-1:0]            wdata;
    logic [3:0][`UMP_DATA_W-1:0]       res;
    logic                              res_retry;
    logic                              res_err;
    logic                              done_tog;
    logic                              req_seen;
  } bus_st_t;

  typedef struct packed {
    logic [`UMP_MASTERS-1:0]           grant;
  } arb_st_t;

endpackage

/* File: sim/sysbus_slave.sv */
`timescale 1ns/1ns

// system bus slave: one beat at a time, quick or slow, retry on command
module sysbus_slave (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        force_retry,
  input  wire logic        sysbus_start,
  input  wire logic [17:0] sysbus_addr,
  output logic      [35:0] sysbus_rdata,
  output logic             sysbus_done,
  output logic             sysbus_retry,
  output logic             sysbus_error
);
  logic        busy;
  logic [2:0]  cnt;
  logic [17:0] adr;

  ////////////////////////////////////////////////////////////////////////
  // read word is the address twice; between beats the data toggles
  // every cycle so that a stale sample can never pass
  always_ff @(posedge clock) begin
    sysbus_done <= 1'b0;
    sysbus_retry <= 1'b0;
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= 3'h0;
      sysbus_rdata <= 36'h0;
    end else if (sysbus_start) begin
      busy <= 1'b1;
      adr <= sysbus_addr;
      cnt <= slow ? 3'h5 : 3'h0;
    end else if (busy && cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end else if (busy) begin
      busy <= 1'b0;
      sysbus_done <= 1'b1;
      sysbus_retry <= force_retry;
      sysbus_rdata <= {adr, adr};
    end else begin
      sysbus_rdata <= ~sysbus_rdata;
    end
  end

  // this slave never flags a bus fault
  assign sysbus_error = 1'b0;
endmodule

/* File: sim/user_master_bus_port_test.sv */
`timescale 1ns/1ns

module user_master_bus_port_test;
  logic        clock, rst_n, uclk, ureset, own, wrq, rdq, bst, stb;
  logic        ack, rty, erf, gdbg, slow, frty, start, wrb, done, brty;
  logic        berr, locked;
  logic [1:0]  sz, bsz;
  logic [17:0] adr, badr;
  logic [35:0] wd, rd, bwd, brd;
  logic [2:0]  oreq, ogr;
  logic [15:0] rnd;
  logic [5:0]  pri[4];
  logic [17:0] la[$];
  logic [35:0] ld[$];
  int          err_total, check_count, rtys, n;

  user_master_bus_port u_dut (.clock(clock), .rst_n(rst_n),
    .master_port_clock(uclk), .master_port_reset(ureset),
    .bus_ownership_request(own), .write_request(wrq), .read_request(rdq),
    .burst_indicator(bst), .transfer_size(sz), .master_address(adr),
    .master_write_data(wd), .request_strobe(stb),
    .master_acknowledge(ack), .retry_response(rty),
    .error_response(erf), .master_read_data(rd),
    .ownership_granted_dbg(gdbg), .other_master_request(oreq),
    .other_master_grant(ogr), .sysbus_start(start), .sysbus_write(wrb),
    .sysbus_size(bsz), .sysbus_addr(badr), .sysbus_wdata(bwd),
    .sysbus_rdata(brd), .sysbus_done(done), .sysbus_retry(brty),
    .sysbus_error(berr));

  sysbus_slave u_slave (.clock(clock), .rst_n(rst_n), .slow(slow),
    .force_retry(frty), .sysbus_start(start), .sysbus_addr(badr),
    .sysbus_rdata(brd), .sysbus_done(done), .sysbus_retry(brty),
    .sysbus_error(berr));

  ////////////////////////////////////////////////////////////////////////
  // bus clock and an unrelated user clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    uclk = 1'b0;
    #7;
    forever #16 uclk = ~uclk;
  end

  // record every beat started on the bus; count retry pulses
  always @(posedge clock) begin
    if (start === 1'b1) begin
      la.push_back(badr);
      ld.push_back(bwd);
      chk("bus_attr", {wrb, bsz}, {wrq, sz});
    end
  end
  always @(posedge uclk) begin
    if (rty === 1'b1)
      rtys++;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // narrow writes repeat the low lanes; parity bits only ride along
  function automatic logic [35:0] wdat(input logic [1:0] s,
                                       input logic [15:0] r);
    case (s)
      2'h0: return {r[11:8], {4{r[7:0]}}};
      2'h1: return {r[3:0], {2{r}}};
      default: return {r[3:0], r, ~r};
    endcase
  endfunction

  task automatic chk(input string nm, input logic [35:0] s,
                     input logic [35:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // bounded wait on the acknowledge (g=0) or the granted flag (g=1)
  task automatic wait_for(input bit g, input logic v);
    int k;
    k = 0;
    do begin
      @(posedge uclk);
      #1;
      k++;
    end while ((g ? gdbg : ack) !== v && k < 400);
    if (k >= 400) begin
      err_total++;
      $display("CHECK FAILED wait expected %h seen timeout", v);
      print_verdict();
    end
  endtask

  task automatic pulse(input logic w, input logic b, input logic [1:0] s,
                       input logic [17:0] a, input logic [35:0] d);
    @(posedge uclk);
    stb <= 1'b1;
    wrq <= w;
    rdq <= !w;
    bst <= b;
    sz <= s;
    adr <= a;
    wd <= d;
  endtask

  // one transfer: strobes, answer, then the beats seen on the bus
  task automatic xfer(input logic w, input logic b, input logic [1:0] s,
                      input logic [17:0] a);
    logic [35:0] d[4];
    logic [17:0] e;
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      d[i] = wdat(s, rnd);
    end
    la.delete();
    ld.delete();
    for (int i = 0; i < ((w && b) ? 4 : 1); i++)
      pulse(w, b, s, a, d[i]);
    @(posedge uclk);
    stb <= 1'b0;
    #1 chk("ack_drop", ack, 1'b0);
    wait_for(1'b0, 1'b1);
    chk("granted", gdbg, locked);
    chk("beats", la.size(), b ? 4 : 1);
    for (int i = 0; i < (b ? 4 : 1); i++) begin
      e = a + (18'(i) << s);
      chk("addr", la[i], e);
      if (w) begin
        chk("wdata", ld[i], d[i]);
      end else begin
        if (i > 0) begin
          @(posedge uclk);
          #1 chk("burst_ack", ack, 1'b1);
        end
        chk("rdata", rd, {e, e});
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rnd = 16'h8804;
    {own, wrq, rdq, bst, stb, slow, frty, locked} = 8'h0;
    sz = 2'h0;
    adr = 18'h0;
    wd = 36'h0;
    oreq = 3'h0;
    pri = '{6'h32, 6'h29, 6'h39, 6'h19};
    rst_n = 1'b0;
    ureset = 1'b1;
    repeat (8) @(posedge clock);
    chk("rst_out", {ack, rty, erf}, 3'h0);
    rst_n <= 1'b1;
    @(posedge uclk);
    ureset <= 1'b0;
    wait_for(1'b0, 1'b1);
    // other masters at once: the lower slot index wins
    foreach (pri[k]) begin
      @(posedge clock);
      oreq <= pri[k][5:3];
      repeat (6) @(posedge clock);
      chk("grant", ogr, pri[k][2:0]);
      oreq <= 3'h0;
      repeat (6) @(posedge clock);
    end
    // single transfers with no lock at all sizes
    for (int s = 0; s < 3; s++) begin
      rnd = lfsr(rnd);
      slow <= rnd[0];
      xfer(1'b1, 1'b0, 2'(s), {rnd, 2'h0});
      xfer(1'b0, 1'b0, 2'(s), {rnd, 2'h0});
    end
    // lock, then back-to-back and burst traffic under the lock
    @(posedge uclk);
    own <= 1'b1;
    wrq <= 1'b1;
    wait_for(1'b1, 1'b1);
    wait_for(1'b0, 1'b1);
    chk("lock_gnt", gdbg, 1'b1);
    locked = 1'b1;
    for (int s = 0; s < 3; s++) begin
      rnd = lfsr(rnd);
      slow <= rnd[1];
      xfer(1'b1, 1'b0, 2'(s), {2'h1, rnd});
      xfer(1'b1, 1'b1, 2'(s), 18'h3fff0);
      xfer(1'b0, 1'b1, 2'(s), {rnd, 2'h0});
      xfer(1'b0, 1'b0, 2'(s), {2'h2, rnd});
    end
    // a read strobe among pending burst write beats is refused
    pulse(1'b1, 1'b1, 2'h2, 18'h40, 36'h0);
    pulse(1'b0, 1'b1, 2'h2, 18'h40, 36'h0);
    @(posedge uclk);
    stb <= 1'b0;
    #1 chk("rd_retry", {rty, ack}, 2'h3);
    // drop the request, then one strobe gives the bus back
    @(posedge uclk);
    own <= 1'b0;
    pulse(1'b1, 1'b0, 2'h2, 18'h0, 36'h0);
    @(posedge uclk);
    stb <= 1'b0;
    locked = 1'b0;
    wait_for(1'b1, 1'b0);
    wait_for(1'b0, 1'b1);
    // invalid size is answered with an error that stands
    pulse(1'b1, 1'b0, 2'h3, 18'h0, 36'h0);
    @(posedge uclk);
    stb <= 1'b0;
    wait_for(1'b0, 1'b1);
    repeat (3) @(posedge uclk);
    #1 chk("err", {ack, erf}, 2'h3);
    // a retry from the bus comes back as one retry pulse
    n = rtys;
    frty <= 1'b1;
    xfer(1'b1, 1'b0, 2'h2, 18'h100);
    @(posedge uclk);
    #1 chk("err_clr", erf, 1'b0);
    chk("retry", rtys - n, 1);
    frty <= 1'b0;
    print_verdict();
  end
endmodule
